// ---- hw/dvm_pkg.sv ----
// dvm_pkg: register map, reset values and ramp timing of the playback volume and mute stage
`default_nettype none
package dvm_pkg;
	// --------------------------------------------------------------
	// register indices; byte address is four times the index
	// --------------------------------------------------------------
	localparam logic [7:0] CTRL_ONE_IDX  = 8'h05; // mute ramp, mute
	localparam logic [7:0] CTRL_TWO_IDX  = 8'h06; // unmute ramp, ramp speed
	localparam logic [7:0] LEFT_VOL_IDX  = 8'h0A; // left code, commit
	localparam logic [7:0] RIGHT_VOL_IDX = 8'h0B; // right code, commit
	localparam logic [7:0] MUTE_ALIAS_IDX = 8'h31; // second home of mute
	localparam logic [7:0] STATUS_IDX    = 8'h32; // ramp level and state
	localparam int         ADDR_W        = 8;
	// --------------------------------------------------------------
	// field positions
	// --------------------------------------------------------------
	localparam int MUTE_RAMP_BIT   = 4; // in control one
	localparam int MUTE_BIT        = 3; // in control one
	localparam int ALIAS_MUTE_BIT  = 4; // in mute alias
	localparam int UNMUTE_RAMP_BIT = 3; // in control two
	localparam int SPEED_BIT       = 2; // in control two
	localparam int COMMIT_BIT      = 8; // in both volume registers
	localparam int RAMPING_BIT     = 8; // in status
	localparam int SILENT_BIT      = 9; // in status
	// --------------------------------------------------------------
	// reset values
	// --------------------------------------------------------------
	localparam logic       MUTE_RST        = 1'b1;
	localparam logic       MUTE_RAMP_RST   = 1'b1;
	localparam logic       UNMUTE_RAMP_RST = 1'b1;
	localparam logic       SPEED_RST       = 1'b0;
	localparam logic [7:0] VOL_RST         = 8'hC0; // unity gain
	// --------------------------------------------------------------
	// ramp timing, counted in samples so it follows the sample rate
	// --------------------------------------------------------------
	localparam int FS_REF_HZ      = 48000;   // rate the ramp times refer to
	localparam int FAST_RAMP_US   = 10700;   // longest fast ramp
	localparam int SLOW_RAMP_US   = 171000;  // longest slow ramp
	localparam int RAMP_STEPS     = 255;     // codes from full scale to mute
	localparam longint FAST_SMP   = longint'(FAST_RAMP_US) * FS_REF_HZ / 1000000;
	localparam longint SLOW_SMP   = longint'(SLOW_RAMP_US) * FS_REF_HZ / 1000000;
	localparam logic [5:0] FAST_PER = 6'((FAST_SMP / RAMP_STEPS) > 0 ? FAST_SMP / RAMP_STEPS : 1);
	localparam logic [5:0] SLOW_PER = 6'((SLOW_SMP / RAMP_STEPS) > 0 ? SLOW_SMP / RAMP_STEPS : 1);
	// --------------------------------------------------------------
	// gain: mantissa of 2^(k*0.375/6.02) in Q1.15, exponent from code[7:4]
	// --------------------------------------------------------------
	localparam logic [15:0] MANT [16] = '{
		16'h8000, 16'h85A6, 16'h8B8C, 16'h91B4, 16'h9822, 16'h9ED8, 16'hA5DA, 16'hAD2B,
		16'hB4CF, 16'hBCC9, 16'hC51D, 16'hCDD0, 16'hD6E4, 16'hE05F, 16'hEA45, 16'hF49B};
	localparam int GAIN_SHIFT = 27; // 15 mantissa bits plus unity exponent 12
	localparam int SMP_W      = 24; // sample width per channel
	localparam int FIFO_DEPTH = 16;
endpackage
`default_nettype wire

// ---- hw/dvm_fifo.sv ----
// dvm_fifo: sample buffer with valid and ready on both sides
`default_nettype none
module dvm_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 16
) (
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	input  wire logic             in_valid,
	output var  logic             in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	// --------------------------------------------------------------
	// storage and pointers
	// --------------------------------------------------------------
	logic [WIDTH-1:0] mem [DEPTH];   // sample words
	logic [AW-1:0]    wr_ptr_reg;    // next slot to fill
	logic [AW-1:0]    rd_ptr_reg;    // oldest word
	logic [AW:0]      count_reg;     // words held
	logic [AW:0]      count_next;
	logic             push;
	logic             pop;

	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_valid = (count_reg != '0);
	assign out_data  = mem[rd_ptr_reg];

	// occupancy after this edge
	always_comb
	begin
		count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
	end

	// pointers and count; ready is registered so it is honest one cycle ahead
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
			in_ready   <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			count_reg <= count_next;
			in_ready  <= (count_next != (AW+1)'(DEPTH));
		end
	end

	// memory write, no reset needed on data
	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end
endmodule // dvm_fifo
`default_nettype wire

// ---- hw/dvm_volume_mute.sv ----
// dvm_volume_mute: stereo playback gain with hard or soft mute, APB registers
`default_nettype none
// How it works
// - comes out of reset muted
// - hard mute drops gain at once
// - soft mute steps gain down to zero
// - hard unmute restores volume at once
// - soft unmute steps gain up to volume
// - speed select picks fast or slow ramp
// - ramp steps count samples, scale with rate
// - mute bit shared by two register locations
// - gain moves 0.375 dB per code
// - reset: soft both ways, fast ramp
// - code X gives 0.375(X-192) dB, zero mutes
// - codes wait pending until commit bit written
module dvm_volume_mute (
	input  wire logic                     sys_clk,
	input  wire logic                     sys_rst,
	input  wire logic [dvm_pkg::ADDR_W-1:0] paddr,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [31:0]              pwdata,
	output var  logic [31:0]              prdata,
	output var  logic                     pready,
	output var  logic                     pslverr,
	input  wire logic                     in_valid,
	output var  logic                     in_ready,
	input  wire logic [23:0]              in_left,
	input  wire logic [23:0]              in_right,
	output var  logic                     out_valid,
	input  wire logic                     out_ready,
	output var  logic [23:0]              out_left,
	output var  logic [23:0]              out_right
);
	// --------------------------------------------------------------
	// control state
	// --------------------------------------------------------------
	logic       mute_reg;          // shared mute bit
	logic       mute_ramp_reg;     // soft mute select
	logic       unmute_ramp_reg;   // soft unmute select
	logic       ramp_speed_select; // 0 fast, 1 slow
	logic [7:0] left_pend_reg;     // written left code
	logic [7:0] right_pend_reg;    // written right code
	logic [7:0] left_gain_code;    // applied left code
	logic [7:0] right_gain_code;   // applied right code
	logic [7:0] ramp_level_reg;    // ceiling on applied codes
	logic       settled_reg;       // unmuted and ramp finished
	logic       mute_q_reg;        // mute one cycle ago
	logic [5:0] step_cnt_reg;      // samples since last step
	logic       step;              // one ramp step due
	logic [7:0] max_code;          // larger applied code
	logic [7:0] eff_left;          // code after ramp ceiling
	logic [7:0] eff_right;
	logic [5:0] step_per;          // samples per ramp step
	logic       sample_tick;       // one input sample taken
	// apb decode
	logic [7:0] reg_idx;
	logic       addr_ok;
	logic       wr_en;
	logic       setup;
	logic [31:0] rd_mux;
	// fifo side
	logic        f_valid;
	logic        f_ready;
	logic [47:0] f_data;
	logic        pop;

	// --------------------------------------------------------------
	// apb slave: answer in the cycle after setup, one wait-free access
	// --------------------------------------------------------------
	assign reg_idx = {2'b00, paddr[dvm_pkg::ADDR_W-1:2]};
	assign setup   = psel && !penable;
	assign wr_en   = psel && penable && pready && pwrite && !pslverr;
	assign addr_ok = (paddr[1:0] == 2'b00) &&
		(reg_idx == dvm_pkg::CTRL_ONE_IDX || reg_idx == dvm_pkg::CTRL_TWO_IDX ||
		 reg_idx == dvm_pkg::LEFT_VOL_IDX || reg_idx == dvm_pkg::RIGHT_VOL_IDX ||
		 reg_idx == dvm_pkg::MUTE_ALIAS_IDX || reg_idx == dvm_pkg::STATUS_IDX);

	// read mux; unused bits read zero, commit bit reads zero
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (reg_idx)
			dvm_pkg::CTRL_ONE_IDX:
			begin
				rd_mux[dvm_pkg::MUTE_RAMP_BIT] = mute_ramp_reg;
				rd_mux[dvm_pkg::MUTE_BIT]      = mute_reg;
			end
			dvm_pkg::CTRL_TWO_IDX:
			begin
				rd_mux[dvm_pkg::UNMUTE_RAMP_BIT] = unmute_ramp_reg;
				rd_mux[dvm_pkg::SPEED_BIT]       = ramp_speed_select;
			end
			dvm_pkg::LEFT_VOL_IDX:   rd_mux[7:0] = left_pend_reg;
			dvm_pkg::RIGHT_VOL_IDX:  rd_mux[7:0] = right_pend_reg;
			dvm_pkg::MUTE_ALIAS_IDX: rd_mux[dvm_pkg::ALIAS_MUTE_BIT] = mute_reg;
			dvm_pkg::STATUS_IDX:
			begin
				rd_mux[7:0]                  = ramp_level_reg;
				rd_mux[dvm_pkg::RAMPING_BIT] = !settled_reg && !(mute_reg && ramp_level_reg == 8'h00);
				rd_mux[dvm_pkg::SILENT_BIT]  = (ramp_level_reg == 8'h00);
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// pready, prdata and pslverr all come from flops; unmapped gets pslverr
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup && !addr_ok;
			prdata  <= (setup && !pwrite && addr_ok) ? rd_mux : 32'h0000_0000;
		end
	end

	// --------------------------------------------------------------
	// control registers
	// --------------------------------------------------------------
	// mute lives in one flop; both locations write it, last write wins
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			mute_reg          <= dvm_pkg::MUTE_RST;
			mute_ramp_reg     <= dvm_pkg::MUTE_RAMP_RST;
			unmute_ramp_reg   <= dvm_pkg::UNMUTE_RAMP_RST;
			ramp_speed_select <= dvm_pkg::SPEED_RST;
		end
		else if (wr_en)
		begin
			if (reg_idx == dvm_pkg::CTRL_ONE_IDX)
			begin
				mute_reg      <= pwdata[dvm_pkg::MUTE_BIT];
				mute_ramp_reg <= pwdata[dvm_pkg::MUTE_RAMP_BIT];
			end
			if (reg_idx == dvm_pkg::MUTE_ALIAS_IDX)
				mute_reg <= pwdata[dvm_pkg::ALIAS_MUTE_BIT];
			if (reg_idx == dvm_pkg::CTRL_TWO_IDX)
			begin
				unmute_ramp_reg   <= pwdata[dvm_pkg::UNMUTE_RAMP_BIT];
				ramp_speed_select <= pwdata[dvm_pkg::SPEED_BIT];
			end
		end
	end

	// volume codes: stored pending, both applied together on commit
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			left_pend_reg   <= dvm_pkg::VOL_RST;
			right_pend_reg  <= dvm_pkg::VOL_RST;
			left_gain_code  <= dvm_pkg::VOL_RST;
			right_gain_code <= dvm_pkg::VOL_RST;
		end
		else if (wr_en && (reg_idx == dvm_pkg::LEFT_VOL_IDX || reg_idx == dvm_pkg::RIGHT_VOL_IDX))
		begin
			if (reg_idx == dvm_pkg::LEFT_VOL_IDX)
				left_pend_reg <= pwdata[7:0];
			else
				right_pend_reg <= pwdata[7:0];
			if (pwdata[dvm_pkg::COMMIT_BIT])
			begin
				// the word being written joins the commit
				left_gain_code  <= (reg_idx == dvm_pkg::LEFT_VOL_IDX) ? pwdata[7:0] : left_pend_reg;
				right_gain_code <= (reg_idx == dvm_pkg::RIGHT_VOL_IDX) ? pwdata[7:0] : right_pend_reg;
			end
		end
	end

	// --------------------------------------------------------------
	// ramp timing: steps counted in input samples, so time follows fs
	// --------------------------------------------------------------
	assign sample_tick = in_valid && in_ready;
	assign step_per    = ramp_speed_select ? dvm_pkg::SLOW_PER : dvm_pkg::FAST_PER;
	assign step        = sample_tick && (step_cnt_reg == step_per - 6'd1);
	assign max_code    = (left_gain_code > right_gain_code) ? left_gain_code : right_gain_code;

	// sample counter between ramp steps; a count at or past a shorter new period restarts it safely
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			step_cnt_reg <= 6'h00;
		else if (step || step_cnt_reg >= step_per)
			step_cnt_reg <= 6'h00;
		else if (sample_tick)
			step_cnt_reg <= step_cnt_reg + 6'd1;
	end

	// --------------------------------------------------------------
	// ramp level: a ceiling on the applied codes, zero meaning silence
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			ramp_level_reg <= 8'h00;   // starts silent, matching mute
			settled_reg    <= 1'b0;
			mute_q_reg     <= dvm_pkg::MUTE_RST;
		end
		else
		begin
			mute_q_reg <= mute_reg;
			if (mute_reg)
			begin
				settled_reg <= 1'b0;
				if (!mute_ramp_reg)
					ramp_level_reg <= 8'h00;
				else if (step && ramp_level_reg != 8'h00)
					ramp_level_reg <= ramp_level_reg - 8'd1;
			end
			else if (settled_reg || !unmute_ramp_reg)
			begin
				// follow the volume so later mutes start from the real gain
				ramp_level_reg <= max_code;
				settled_reg    <= 1'b1;
			end
			else if (ramp_level_reg >= max_code)
			begin
				ramp_level_reg <= max_code;
				settled_reg    <= 1'b1;
			end
			else if (step)
				ramp_level_reg <= ramp_level_reg + 8'd1;
		end
	end

	assign eff_left  = (left_gain_code < ramp_level_reg) ? left_gain_code : ramp_level_reg;
	assign eff_right = (right_gain_code < ramp_level_reg) ? right_gain_code : ramp_level_reg;

	// --------------------------------------------------------------
	// gain: mantissa times power of two; exactly 6 dB per 16 codes is
	// taken as one octave, a 0.3 percent error traded for no log table
	// --------------------------------------------------------------
	function automatic logic [23:0] apply_gain(input logic [23:0] smp, input logic [7:0] code);
		logic signed [40:0] prod;
		logic signed [55:0] wide;
		logic signed [55:0] sh;
		prod = $signed(smp) * $signed({1'b0, dvm_pkg::MANT[code[3:0]]});
		wide = 56'(prod);
		sh   = (wide <<< code[7:4]) >>> dvm_pkg::GAIN_SHIFT;
		if (code == 8'h00)
			apply_gain = 24'h00_0000;
		else if (sh > 56'sh7F_FFFF)
			apply_gain = 24'h7F_FFFF;
		else if (sh < -56'sh80_0000)
			apply_gain = 24'h80_0000;
		else
			apply_gain = sh[23:0];
	endfunction

	// --------------------------------------------------------------
	// sample path: fifo then one registered gain stage
	// --------------------------------------------------------------
	dvm_fifo #(
		.WIDTH (48),
		.DEPTH (dvm_pkg::FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.in_valid  (in_valid),
		.in_ready  (in_ready),
		.in_data   ({in_left, in_right}),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data)
	);

	// stalls when the consumer holds off, which backs the fifo up
	assign f_ready = !out_valid || out_ready;
	assign pop     = f_valid && f_ready;

	// output stage holds a sample until the consumer takes it
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			out_valid <= 1'b0;
			out_left  <= 24'h00_0000;
			out_right <= 24'h00_0000;
		end
		else if (pop)
		begin
			out_valid <= 1'b1;
			out_left  <= apply_gain(f_data[47:24], eff_left);
			out_right <= apply_gain(f_data[23:0], eff_right);
		end
		else if (out_ready)
			out_valid <= 1'b0;
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	sequence s_hard_mute_req;
		$rose(mute_reg) && !mute_ramp_reg;
	endsequence

	sequence s_hard_unmute_req;
		$fell(mute_reg) && !unmute_ramp_reg;
	endsequence

	a_reset_muted: assert property (@(posedge sys_clk)
		$past(sys_rst) && !sys_rst |-> mute_reg && ramp_level_reg == 8'h00)
		else $error("not muted after reset");
	a_reset_selects: assert property (@(posedge sys_clk)
		$past(sys_rst) && !sys_rst |-> mute_ramp_reg && unmute_ramp_reg && !ramp_speed_select)
		else $error("wrong ramp selects after reset");
	a_hard_mute_now: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_hard_mute_req |=> ramp_level_reg == 8'h00 ##1 ramp_level_reg == 8'h00)
		else $error("hard mute did not silence at once");
	a_soft_mute_step: assert property (@(posedge sys_clk) disable iff (sys_rst)
		mute_reg && mute_ramp_reg && step && ramp_level_reg != 8'h00
		|=> ramp_level_reg == $past(ramp_level_reg) - 8'd1)
		else $error("soft mute did not step down");
	a_hard_unmute_now: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_hard_unmute_req |=> ramp_level_reg == $past(max_code))
		else $error("hard unmute did not restore volume");
	a_soft_unmute_rise: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!mute_reg && unmute_ramp_reg && !settled_reg && ramp_level_reg < max_code
		|=> ramp_level_reg == $past(ramp_level_reg) + 8'($past(step)))
		else $error("soft unmute jumped");
	a_step_period: assert property (@(posedge sys_clk) disable iff (sys_rst)
		sample_tick && step_cnt_reg < step_per |=> step_cnt_reg ==
		(($past(step_cnt_reg) == ($past(ramp_speed_select) ? dvm_pkg::SLOW_PER
		: dvm_pkg::FAST_PER) - 6'd1) ? 6'h00 : $past(step_cnt_reg) + 6'd1))
		else $error("ramp step at wrong sample count");
	a_step_on_sample: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$changed(ramp_level_reg) && mute_reg && $past(mute_ramp_reg) && $past(mute_reg)
		|-> $past(sample_tick))
		else $error("ramp moved without a sample");
	a_mute_alias: assert property (@(posedge sys_clk) disable iff (sys_rst)
		wr_en && reg_idx == dvm_pkg::MUTE_ALIAS_IDX |=> mute_reg == $past(pwdata[dvm_pkg::ALIAS_MUTE_BIT]))
		else $error("alias write missed mute");
	a_unity_gain: assert property (@(posedge sys_clk) disable iff (sys_rst)
		pop && eff_left == 8'hC0 |=> out_left == $past(f_data[47:24]))
		else $error("unity code altered the sample");
	a_zero_code_mute: assert property (@(posedge sys_clk) disable iff (sys_rst)
		pop && eff_right == 8'h00 |=> out_right == 24'h00_0000)
		else $error("code zero not silent");
	a_commit_both: assert property (@(posedge sys_clk) disable iff (sys_rst)
		wr_en && reg_idx == dvm_pkg::LEFT_VOL_IDX && pwdata[dvm_pkg::COMMIT_BIT]
		|=> left_gain_code == $past(pwdata[7:0]) && right_gain_code == $past(right_pend_reg))
		else $error("commit did not load both codes");
	a_no_jump_toggle: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$changed(mute_reg) && mute_ramp_reg && unmute_ramp_reg
		|=> ramp_level_reg <= $past(ramp_level_reg) + 9'd1 && ramp_level_reg + 9'd1 >= $past(ramp_level_reg))
		else $error("ramp jumped on toggle");
endmodule // dvm_volume_mute
`default_nettype wire

// ---- tb/dvm_src_model.sv ----
// dvm_src_model: playback sample source that stands in for the digital audio interface
`default_nettype none
module dvm_src_model (
	input  wire logic        sys_clk,  // system clock
	input  wire logic        sys_rst,  // synchronous reset, active high
	input  wire logic        run,      // bench asks for samples
	input  wire logic        in_ready, // stage can take a sample
	output var  logic        in_valid, // sample offered
	output var  logic [23:0] in_left,  // left sample
	output var  logic [23:0] in_right, // right sample
	output wire logic        taken     // sample accepted at this edge
);
	timeunit 1ns;
	timeprecision 1ns;
	// --------------------------------------------------------------
	// handshake
	// --------------------------------------------------------------
	assign taken = in_valid & in_ready;
	// known levels before the first edge
	initial
	begin
		in_valid = 1'h0;
		in_left = 24'h0;
		in_right = 24'h0;
	end
	// an offer holds until taken; random gaps mimic a slower interface
	always @(posedge sys_clk)
		if (sys_rst)
			in_valid <= 1'h0;
		else if (in_valid !== 1'h1 || in_ready === 1'h1)
			in_valid <= run && ($urandom_range(3) != 0);
	// data hold while offered, otherwise a fresh pattern every cycle
	// so that a stale word is never mistaken for a good one
	always @(posedge sys_clk)
		if (in_valid !== 1'h1 || in_ready === 1'h1)
		begin
			in_left <= 24'($urandom);
			in_right <= 24'($urandom);
		end
endmodule // dvm_src_model
`default_nettype wire

// ---- tb/dvm_volume_mute_tb.sv ----
// dvm_volume_mute_tb: self-checking bench for the playback volume and mute stage
`default_nettype none
`define CHK(n, x, g) begin comparisons++; if ((g) !== (x)) begin miscompares++; \
	$display("unexpected %s expected %h seen %h", n, x, g); end end
module dvm_volume_mute_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// --------------------------------------------------------------
	// signals
	// --------------------------------------------------------------
	logic        sys_clk = 1'h0;                      // 10 MHz
	logic        sys_rst = 1'h1;                      // held 4 cycles
	logic [7:0]  paddr = 8'h0;                        // apb byte address
	logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [31:0] pwdata = 32'h0, prdata;              // apb data
	logic        pready, pslverr;                     // apb answer
	logic        in_valid, in_ready, out_valid, out_ready = 1'h0;
	logic [23:0] in_left, in_right, out_left, out_right;
	logic        run = 1'h0, stall = 1'h0, taken;     // source and sink control
	logic [1:0]  mode = 2'h0;                         // 0 skip, 1 pass, 2 silent, 3 left x2
	logic [48:0] expq[$];                             // check flag and expected pair
	logic [48:0] e;                                   // note under comparison
	logic [31:0] rd;                                  // last read data
	logic        err;                                 // last error flag
	int          miscompares = 0, comparisons = 0, cycles = 0, ntaken = 0, base;
	always #50 sys_clk = ~sys_clk;
	dvm_volume_mute i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready),
		.in_left(in_left), .in_right(in_right), .out_valid(out_valid),
		.out_ready(out_ready), .out_left(out_left), .out_right(out_right));
	dvm_src_model i_src (.sys_clk(sys_clk), .sys_rst(sys_rst), .run(run), .in_ready(in_ready),
		.in_valid(in_valid), .in_left(in_left), .in_right(in_right), .taken(taken));
	// --------------------------------------------------------------
	// sink, expectations and monitor
	// --------------------------------------------------------------
	// the sink stalls at random so outputs must hold
	always @(posedge sys_clk)
		out_ready <= !stall && ($urandom_range(3) != 0);
	// doubling with saturation, the effect of sixteen codes above unity
	function automatic logic [23:0] dbl(input logic [23:0] x);
		if (x[23] != x[22])
			return x[23] ? 24'h800000 : 24'h7FFFFF;
		return {x[22:0], 1'h0};
	endfunction
	// note the expected result of each accepted sample
	always @(posedge sys_clk)
		if (taken === 1'h1)
		begin
			ntaken++;
			case (mode)
				2'h1: expq.push_back({1'h1, in_left, in_right});
				2'h2: expq.push_back({1'h1, 48'h0});
				2'h3: expq.push_back({1'h1, dbl(in_left), 24'h0});
				default: expq.push_back(49'h0); // ramping, level read instead
			endcase
		end
	// compare each delivered sample with the oldest note
	always @(posedge sys_clk)
		if (out_valid === 1'h1 && out_ready === 1'h1)
		begin
			e = (expq.size() > 0) ? expq.pop_front() : {1'h1, 48'hX};
			if (e[48])
				`CHK("sample", e[47:0], {out_left, out_right})
		end
	// --------------------------------------------------------------
	// tasks
	// --------------------------------------------------------------
	// one apb transfer; the request holds until pready is seen high
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge sys_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, idx[5:0], 2'h0, wd};
		@(posedge sys_clk);
		penable <= 1'h1;
		do @(posedge sys_clk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task automatic chk_reg(input logic [7:0] idx, input logic [31:0] x);
		apb(1'h0, idx, 32'h0);
		`CHK("register", x, rd)
	endtask
	// ramp level window and the ramping and silent flags
	task automatic level(input int lo, input int hi, input logic [1:0] flags);
		apb(1'h0, dvm_pkg::STATUS_IDX, 32'h0);
		`CHK("ramp level", 1'h1, rd[7:0] >= lo && rd[7:0] <= hi)
		`CHK("ramp flags", flags, rd[9:8])
	endtask
	// wait until every sample has left the stage
	task automatic drain();
		do @(posedge sys_clk); while (expq.size() != 0 || in_valid !== 1'h0);
	endtask
	task automatic stream(input int n);
		base = ntaken;
		run <= 1'h1;
		while (ntaken - base < n) @(posedge sys_clk);
		run <= 1'h0;
		drain();
	endtask
	task automatic conclude();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// hang guard, far above the some fifteen hundred cycles the run needs
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			miscompares++;
			conclude();
		end
	end
	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial
	begin
		void'($urandom(81));
		repeat (4) @(posedge sys_clk);
		sys_rst <= 1'h0;
		chk_reg(dvm_pkg::CTRL_ONE_IDX, 32'h18);
		chk_reg(dvm_pkg::CTRL_TWO_IDX, 32'h08);
		chk_reg(dvm_pkg::MUTE_ALIAS_IDX, 32'h10);
		chk_reg(dvm_pkg::LEFT_VOL_IDX, 32'hC0);
		chk_reg(dvm_pkg::STATUS_IDX, 32'h200);
		apb(1'h0, 8'h3F, 32'h0);                   // unmapped place
		`CHK("error flag", 1'h1, err)
		`CHK("error data", 32'h0, rd)
		mode <= 2'h2;
		stream(20);
		// hard unmute, mute cleared through its second home
		apb(1'h1, dvm_pkg::CTRL_TWO_IDX, 32'h0);
		apb(1'h1, dvm_pkg::MUTE_ALIAS_IDX, 32'h0);
		chk_reg(dvm_pkg::CTRL_ONE_IDX, 32'h10);
		mode <= 2'h1;
		stream(30);
		apb(1'h1, dvm_pkg::LEFT_VOL_IDX, 32'hD0);  // pending only
		stream(20);
		apb(1'h1, dvm_pkg::RIGHT_VOL_IDX, 32'h100);
		mode <= 2'h3;
		stream(30);
		apb(1'h1, dvm_pkg::RIGHT_VOL_IDX, 32'hC0);
		apb(1'h1, dvm_pkg::LEFT_VOL_IDX, 32'h1C0);
		apb(1'h1, dvm_pkg::CTRL_ONE_IDX, 32'h08);  // hard mute
		mode <= 2'h2;
		stream(20);
		// soft unmute, fast; then soft mute in mid ramp
		apb(1'h1, dvm_pkg::CTRL_TWO_IDX, 32'h08);
		apb(1'h1, dvm_pkg::CTRL_ONE_IDX, 32'h10);
		mode <= 2'h0;
		stream(40);
		level(19, 21, 2'h1);
		apb(1'h1, dvm_pkg::CTRL_ONE_IDX, 32'h18);
		stream(10);
		level(13, 17, 2'h1);
		stream(60);
		level(0, 0, 2'h2);
		// slow ramp, then fast to the end
		apb(1'h1, dvm_pkg::CTRL_TWO_IDX, 32'h0C);
		apb(1'h1, dvm_pkg::CTRL_ONE_IDX, 32'h10);
		stream(64);
		level(1, 3, 2'h1);
		apb(1'h1, dvm_pkg::CTRL_TWO_IDX, 32'h08);
		stream(400);
		level(192, 192, 2'h0);
		mode <= 2'h1;
		stream(20);
		// buffer fills while the sink stalls, then drains
		stall <= 1'h1;
		base = ntaken;
		run <= 1'h1;
		repeat (60) @(posedge sys_clk);
		run <= 1'h0;
		`CHK("accepted", 17, ntaken - base)
		`CHK("in ready", 1'h0, in_ready)
		stall <= 1'h0;
		drain();
		conclude();
	end
endmodule // dvm_volume_mute_tb
`undef CHK
`default_nettype wire
